// *** pcc_consts.svh ***
// Purpose: named offsets, field positions, reset values of the channel
// Assumes: included by bare name after the package
// Notes: definitions only
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

// ==========================================================
// register offsets (byte addresses, one word each)
`define PCC_OFF_CTRL1 8'h04
`define PCC_OFF_PERIOD 8'h10
`define PCC_OFF_PRESET 8'h14
`define PCC_OFF_EVENTS 8'h18
`define PCC_OFF_TRIG2 8'h1c
`define PCC_OFF_LEVELS 8'h20
`define PCC_OFF_STATUS 8'h24

// ==========================================================
// control register one field positions
`define PCC_F_PRESET 31
`define PCC_F_RECT 30
`define PCC_F_BURST 29
`define PCC_F_ADJ 28
`define PCC_F_DIV_HI 27
`define PCC_F_DIV_LO 24
`define PCC_F_SCALE_HI 23
`define PCC_F_SCALE_LO 21
`define PCC_F_EXT 20
`define PCC_F_BOTH 19
`define PCC_F_AUTO 18
`define PCC_F_UPD_HI 17
`define PCC_F_UPD_LO 16
`define PCC_F_OVR 15
`define PCC_F_GLOBAL 14
`define PCC_F_DIR_B 13
`define PCC_F_DIR_A 12
`define PCC_F_LVL_B 11
`define PCC_F_GPIO_B 10
`define PCC_F_LVL_A 9
`define PCC_F_GPIO_A 8
`define PCC_F_SFRAME 6
`define PCC_F_PBLK_B 5
`define PCC_F_PBLK_A 4
`define PCC_F_FINE_HI 3
`define PCC_F_FINE_LO 2

// ==========================================================
// reset values and codes
`define PCC_CTRL1_RST 32'h0001_8002
`define PCC_PERIOD_RST 16'h00ff
`define PCC_UPD_ANY 2'h0
`define PCC_FINE_FULL 5'h10
`define PCC_DUTY_MAX 16'hffff

`endif

// *** pcc_pkg.sv ***
// Purpose: types shared by the channel control files
// Assumes: constants come from pcc_consts.svh
// Notes: state of the shaper and of the channel control is one packed struct each
package pcc_pkg;

   // ==========================================================
   // pin drive pair
   typedef struct packed {
      logic o;
      logic oe;
   } pcc_pin_t;

   // ==========================================================
   // single-step frame sequencer, gray along free-run-wait
   typedef enum logic [1:0] {
      FR_FREE = 2'b00,
      FR_RUN = 2'b01,
      FR_WAIT = 2'b11
   } pcc_frame_t;

   typedef struct packed {
      logic [31:0] ctrl1;
      logic [15:0] period;
      logic [15:0] preset;
      logic [31:0] evt_shadow;
      logic [31:0] evt_act;
      logic upd_pend;
      logic [15:0] trig2;
      logic [31:0] levels;
      logic [15:0] cnt;
      logic [3:0] div_cnt;
      logic sync_out;
      logic sample_req;
      pcc_pin_t pin_a;
      pcc_pin_t pin_b;
      logic limit_hold;
      logic cfg_err;
      logic burst_active;
      logic auto_active;
      pcc_frame_t frame;
      logic trig_last;
      logic [4:0] fine_phases;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pcc_state_t;

   typedef struct packed {
      logic [15:0] duty;
   } pcc_shaper_t;

endpackage : pcc_pkg

// *** pcc_duty_shaper.sv ***
// Purpose: scale and balance-adjust the control-law duty value
// Assumes: inputs synchronous to pclk
// Notes: result saturates to 0..ffff, one cycle of latency
`timescale 1ns/10ps
module pcc_duty_shaper
   import pcc_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, low
   input wire logic [15:0] law_duty, // control-law duty
   input wire logic [2:0] scale, // input scaling code
   input wire logic adjust_en, // balance adjust enable
   input wire logic signed [15:0] balance_corr, // balancing correction
   output logic [15:0] duty // shaped duty
);
   `include "pcc_consts.svh"

   pcc_shaper_t q;
   pcc_shaper_t d;
   logic [18:0] scaled;
   logic signed [20:0] sum;

   // ==========================================================
   // scaling and adjust
   always_comb begin
      case (scale)
         3'h1: scaled = {3'h0, law_duty} << 1;
         3'h3: scaled = {3'h0, law_duty} << 2;
         3'h5: scaled = {3'h0, law_duty} << 3;
         3'h2: scaled = {3'h0, law_duty >> 1};
         3'h4: scaled = {3'h0, law_duty >> 2};
         3'h6: scaled = {3'h0, law_duty >> 3};
         default: scaled = {3'h0, law_duty};
      endcase
      sum = $signed({2'h0, scaled});
      if (adjust_en) begin
         sum = sum + 21'(balance_corr);
      end
      // clamp rather than wrap: a wrapped duty would flip the output
      if (sum < 0) begin
         d.duty = 16'h0000;
      end else if (sum > $signed({5'h00, `PCC_DUTY_MAX})) begin
         d.duty = `PCC_DUTY_MAX;
      end else begin
         d.duty = sum[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign duty = q.duty;

endmodule : pcc_duty_shaper

// *** pcc_channel_ctrl.sv ***
// Purpose: second control register of one pulse modulator channel
// Assumes: APB slave, one wait state, pins sampled on pclk
// Notes: control register one at 0x04, helper registers around it
//
// Contract
// - on sync, counter goes to zero, or to preset count when enabled
// - rectifier bit on switches synchronous rectifier mode for pin B
// - light-load burst detection only while its enable is set
// - balancing correction adjusts control-law duty only while enabled
// - sync out pulses once every N+1 switching cycles, 0 every cycle
// - scaling code multiplies or divides control-law value by 2/4/8
// - external sync slaves the counter only while enabled
// - multi/resonant limit acts on A active, or A or B when set
// - automatic mode switching only while its select bit is set
// - event update timing: any, end of period, trigger 2, or both
// - override clear checks events and refuses invalid ones
// - period source is own register or shared global period
// - direction bit clear drives pin, set makes it an input
// - general-purpose mode replaces modulated waveform on the pin
// - general-purpose pin driven to its static level bit
// - single frame: sample, one duty cycle, then wait trigger toggle
// - protection block bit keeps protection from turning pin off
// - fine step select gives 16, 8, 4 or 2 phases
`timescale 1ns/10ps
module pcc_channel_ctrl
   import pcc_pkg::*;
(
   input wire logic pclk, // 50 MHz clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic [15:0] law_duty, // control-law duty value
   input wire logic [15:0] balance_corr, // signed balance correction
   input wire logic [15:0] global_period, // shared period value
   input wire logic ext_sync, // external sync pulse
   input wire logic multi_mode, // multi or resonant mode selected
   input wire logic limit_fault, // cycle-by-cycle limit fault
   input wire logic async_prot, // protection turn-off request
   input wire logic frame_trigger, // single-frame trigger level
   input wire logic pin_a_i, // pin A level when input
   input wire logic pin_b_i, // pin B level when input
   output pcc_pin_t pin_a, // pin A drive and enable
   output pcc_pin_t pin_b, // pin B drive and enable
   output logic sync_out, // divided sync out pulse
   output logic sample_req, // converter sample request pulse
   output logic [4:0] fine_phases, // fine step phase count
   output logic rectifier_mode, // synchronous rectifier active
   output logic auto_mode // auto switched mode active
);
   `include "pcc_consts.svh"

   pcc_state_t q;
   pcc_state_t d;
   logic [15:0] duty;
   logic [15:0] per;
   logic [15:0] evt_rise;
   logic [15:0] evt_fall;
   logic access;
   logic wr;
   logic eop;
   logic sync_hit;
   logic gate;
   logic a_raw;
   logic b_raw;
   logic limit_act;
   logic upd_now;
   logic [3:0] div_n;
   logic [1:0] upd_mode;

   // ==========================================================
   // helpers
   function automatic logic reg_hit(input logic [7:0] a);
      case (a)
         `PCC_OFF_CTRL1, `PCC_OFF_PERIOD, `PCC_OFF_PRESET,
         `PCC_OFF_EVENTS, `PCC_OFF_TRIG2, `PCC_OFF_LEVELS,
         `PCC_OFF_STATUS: reg_hit = 1'b1;
         default: reg_hit = 1'b0;
      endcase
   endfunction : reg_hit

   function automatic logic in_window(input logic [15:0] c,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
      in_window = (c >= lo) && (c < hi);
   endfunction : in_window

   function automatic pcc_pin_t drive_pin(input logic gpio_en,
                                          input logic level,
                                          input logic dir_in,
                                          input logic raw,
                                          input logic kill);
      pcc_pin_t p;
      p.oe = ~dir_in;
      if (gpio_en) begin
         p.o = level;
      end else begin
         p.o = raw & ~kill;
      end
      drive_pin = p;
   endfunction : drive_pin

   // ==========================================================
   // duty shaping
   pcc_duty_shaper u_shaper (
      .pclk(pclk),
      .presetn(presetn),
      .law_duty(law_duty),
      .scale(q.ctrl1[`PCC_F_SCALE_HI:`PCC_F_SCALE_LO]),
      .adjust_en(q.ctrl1[`PCC_F_ADJ]),
      .balance_corr(balance_corr),
      .duty(duty)
   );

   // ==========================================================
   // next state
   always_comb begin
      d = q;
      per = q.ctrl1[`PCC_F_GLOBAL] ? global_period : q.period;
      evt_rise = q.evt_act[15:0];
      evt_fall = q.evt_act[31:16];
      div_n = q.ctrl1[`PCC_F_DIV_HI:`PCC_F_DIV_LO];
      upd_mode = q.ctrl1[`PCC_F_UPD_HI:`PCC_F_UPD_LO];
      eop = ({1'b0, q.cnt} + 17'h00001) >= {1'b0, per};
      sync_hit = ext_sync & q.ctrl1[`PCC_F_EXT];

      // apb: access phase takes two cycles, pready from a flop
      access = psel & penable;
      wr = access & q.pready & pwrite & reg_hit(paddr);
      d.pready = access & ~q.pready;
      d.pslverr = 1'b0;
      if (access & ~q.pready) begin
         d.pslverr = ~reg_hit(paddr);
         case (paddr)
            `PCC_OFF_CTRL1: d.prdata = q.ctrl1;
            `PCC_OFF_PERIOD: d.prdata = {16'h0000, q.period};
            `PCC_OFF_PRESET: d.prdata = {16'h0000, q.preset};
            `PCC_OFF_EVENTS: d.prdata = q.evt_act;
            `PCC_OFF_TRIG2: d.prdata = {16'h0000, q.trig2};
            `PCC_OFF_LEVELS: d.prdata = q.levels;
            `PCC_OFF_STATUS: d.prdata = {q.cnt, 9'h000,
               pin_b_i, pin_a_i, q.frame == FR_WAIT, q.limit_hold,
               q.auto_active, q.burst_active, q.cfg_err};
            default: d.prdata = 32'h0000_0000;
         endcase
      end
      if (wr) begin
         case (paddr)
            `PCC_OFF_CTRL1: d.ctrl1 = pwdata;
            `PCC_OFF_PERIOD: d.period = pwdata[15:0];
            `PCC_OFF_PRESET: d.preset = pwdata[15:0];
            `PCC_OFF_TRIG2: d.trig2 = pwdata[15:0];
            `PCC_OFF_LEVELS: d.levels = pwdata;
            default: d.levels = q.levels;
         endcase
      end

      // single-step frame sequencer
      d.sample_req = 1'b0;
      d.trig_last = frame_trigger;
      case (q.frame)
         FR_FREE: begin
            if (q.ctrl1[`PCC_F_SFRAME]) begin
               d.frame = FR_RUN;
               d.sample_req = 1'b1;
            end
         end
         FR_RUN: begin
            if (!q.ctrl1[`PCC_F_SFRAME]) begin
               d.frame = FR_FREE;
            end else if (eop) begin
               d.frame = FR_WAIT;
            end
         end
         FR_WAIT: begin
            if (!q.ctrl1[`PCC_F_SFRAME]) begin
               d.frame = FR_FREE;
            end else if (frame_trigger != q.trig_last) begin
               d.frame = FR_RUN;
               d.sample_req = 1'b1;
            end
         end
         default: d.frame = FR_FREE;
      endcase

      // period counter
      if (q.frame == FR_WAIT) begin
         d.cnt = 16'h0000;
      end else if (sync_hit) begin
         d.cnt = q.ctrl1[`PCC_F_PRESET] ? q.preset : 16'h0000;
      end else if (eop) begin
         d.cnt = 16'h0000;
      end else begin
         d.cnt = q.cnt + 16'h0001;
      end

      // sync out divider, one pulse per div_n+1 periods
      d.sync_out = 1'b0;
      if (eop && q.frame != FR_WAIT) begin
         if (q.div_cnt >= div_n) begin
            d.div_cnt = 4'h0;
            d.sync_out = 1'b1;
         end else begin
            d.div_cnt = q.div_cnt + 4'h1;
         end
      end

      // light-load burst and auto switching, judged per period
      if (eop) begin
         d.burst_active = q.ctrl1[`PCC_F_BURST] &&
                          (duty < q.levels[15:0]);
         d.auto_active = q.ctrl1[`PCC_F_AUTO] &&
                         (duty < q.levels[31:16]);
      end
      if (!q.ctrl1[`PCC_F_BURST]) begin
         d.burst_active = 1'b0;
      end
      if (!q.ctrl1[`PCC_F_AUTO]) begin
         d.auto_active = 1'b0;
      end

      // raw waveforms
      gate = ~q.burst_active & ~q.limit_hold & (q.frame != FR_WAIT);
      a_raw = gate & (q.cnt < duty);
      if (q.ctrl1[`PCC_F_RECT]) begin
         b_raw = gate & ~(q.cnt < duty);
      end else begin
         b_raw = gate & in_window(q.cnt, evt_rise, evt_fall);
      end

      // cycle-by-cycle limit, held to end of period; set wins
      if (multi_mode | q.auto_active) begin
         limit_act = limit_fault &
                     (a_raw | (q.ctrl1[`PCC_F_BOTH] & b_raw));
      end else begin
         limit_act = limit_fault;
      end
      if (eop) begin
         d.limit_hold = 1'b0;
      end
      if (limit_act) begin
         d.limit_hold = 1'b1;
         a_raw = 1'b0;
         b_raw = 1'b0;
      end

      // event shadow and guarded update
      if (wr && paddr == `PCC_OFF_EVENTS) begin
         d.evt_shadow = pwdata;
         d.upd_pend = 1'b1;
      end
      upd_now = (upd_mode == `PCC_UPD_ANY) ||
                (upd_mode[0] && eop) ||
                (upd_mode[1] && q.cnt == q.trig2);
      if (q.upd_pend && upd_now) begin
         d.upd_pend = wr && paddr == `PCC_OFF_EVENTS;
         if (!q.ctrl1[`PCC_F_OVR] &&
             (q.evt_shadow[15:0] > q.evt_shadow[31:16] ||
              q.evt_shadow[31:16] > per)) begin
            d.cfg_err = 1'b1;
         end else begin
            d.evt_act = q.evt_shadow;
            d.cfg_err = 1'b0;
         end
      end

      // pin drive
      d.pin_a = drive_pin(q.ctrl1[`PCC_F_GPIO_A], q.ctrl1[`PCC_F_LVL_A],
                          q.ctrl1[`PCC_F_DIR_A], a_raw,
                          async_prot & ~q.ctrl1[`PCC_F_PBLK_A]);
      d.pin_b = drive_pin(q.ctrl1[`PCC_F_GPIO_B], q.ctrl1[`PCC_F_LVL_B],
                          q.ctrl1[`PCC_F_DIR_B], b_raw,
                          async_prot & ~q.ctrl1[`PCC_F_PBLK_B]);

      d.fine_phases = `PCC_FINE_FULL >>
                      q.ctrl1[`PCC_F_FINE_HI:`PCC_F_FINE_LO];
   end

   // ==========================================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.ctrl1 <= `PCC_CTRL1_RST;
         q.period <= `PCC_PERIOD_RST;
         q.frame <= FR_FREE;
         q.fine_phases <= `PCC_FINE_FULL;
         q.pin_a.oe <= 1'b1;
         q.pin_b.oe <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // outputs
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign pin_a = q.pin_a;
   assign pin_b = q.pin_b;
   assign sync_out = q.sync_out;
   assign sample_req = q.sample_req;
   assign fine_phases = q.fine_phases;
   assign rectifier_mode = q.ctrl1[`PCC_F_RECT];
   assign auto_mode = q.auto_active;

endmodule : pcc_channel_ctrl

// *** pcc_stage_model.sv ***
// Purpose: power stage side of the two channel pins
// Assumes: stage drives a level only where the channel lets go of a pin
// Notes: resolved wire level is fed back to the pin inputs
`timescale 1ns/10ps
module pcc_stage_model
   import pcc_pkg::*;
(
   input wire pcc_pin_t pin_a, // channel drive of pin A
   input wire pcc_pin_t pin_b, // channel drive of pin B
   input wire logic drv_a, // stage level on pin A
   input wire logic drv_b, // stage level on pin B
   output logic pin_a_i, // resolved pin A
   output logic pin_b_i // resolved pin B
);
   // ==========================================
   // wire resolution
   // a released pin shows the stage level, never a held copy
   assign pin_a_i = pin_a.oe ? pin_a.o : drv_a;
   assign pin_b_i = pin_b.oe ? pin_b.o : drv_b;
endmodule : pcc_stage_model

// *** pcc_channel_ctrl_asserts.sv ***
// Purpose: port checker for the channel control block
// Assumes: ctrl1 and period mirrored from completed apb writes
// Notes: bound to pcc_channel_ctrl by the bind below
`timescale 1ns/10ps
`include "pcc_consts.svh"
module pcc_channel_ctrl_asserts
   import pcc_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic ext_sync, // external sync
   input wire logic limit_fault, // limit fault
   input wire pcc_pin_t pin_a, // pin A drive
   input wire logic sync_out, // sync out pulse
   input wire logic [4:0] fine_phases, // phase count
   input wire logic rectifier_mode, // rectifier active
   input wire logic auto_mode // auto mode active
);
   logic [31:0] sh_q;
   logic [15:0] per_q;
   logic [20:0] gap_q;
   logic [1:0] chg_q;
   logic flt_q;
   logic wr_ok;
   logic mapped;
   logic cfg_wr;
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;
   assign mapped = paddr inside {8'h04, 8'h10, 8'h14, 8'h18, 8'h1c,
      8'h20, 8'h24};
   assign cfg_wr = wr_ok && paddr inside {`PCC_OFF_CTRL1, `PCC_OFF_PERIOD};
   // two pulses skipped after any change: divider may hold stale phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_q <= `PCC_CTRL1_RST;
         per_q <= `PCC_PERIOD_RST;
         gap_q <= 21'h0;
         chg_q <= 2'h2;
         flt_q <= 1'b0;
      end else begin
         if (wr_ok && paddr == `PCC_OFF_CTRL1)
            sh_q <= pwdata;
         if (wr_ok && paddr == `PCC_OFF_PERIOD)
            per_q <= pwdata[15:0];
         gap_q <= sync_out ? 21'h1 : gap_q + 21'h1;
         if (limit_fault)
            flt_q <= 1'b1;
         if (cfg_wr || ext_sync || sh_q[6] || sh_q[14])
            chg_q <= 2'h2;
         else if (sync_out && chg_q != 2'h0)
            chg_q <= chg_q - 2'h1;
      end
   end
   // ==========================================
   // properties
   default clocking cb_clk @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access; $rose(penable) && psel; endsequence
   sequence s_wait; !pready ##1 pready; endsequence
   property p_apb_wait; s_access |-> s_wait; endproperty
   a_apb_wait: assert property (p_apb_wait)
      else $error("apb answer not after one wait state");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready longer than one cycle");
   property p_unmapped;
      pready && !mapped |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");
   property p_rect; rectifier_mode == sh_q[30]; endproperty
   a_rect: assert property (p_rect)
      else $error("rectifier mode differs from control bit");
   property p_fine;
      sh_q[3:2] == $past(sh_q[3:2]) |-> fine_phases == 5'h10 >> sh_q[3:2];
   endproperty
   a_fine: assert property (p_fine)
      else $error("fine phase count wrong");
   property p_dir_a;
      sh_q[12] == $past(sh_q[12]) |-> pin_a.oe == !sh_q[12];
   endproperty
   a_dir_a: assert property (p_dir_a)
      else $error("pin A direction wrong");
   property p_gpio_a;
      sh_q[8] && !sh_q[12] && !sh_q[6] && !flt_q &&
         $past(sh_q[9:8]) == sh_q[9:8] |-> pin_a.o == sh_q[9];
   endproperty
   a_gpio_a: assert property (p_gpio_a)
      else $error("pin A static level wrong");
   property p_sync_gap;
      sync_out && chg_q == 2'h0 |->
         gap_q == (21'(sh_q[27:24]) + 21'h1) * 21'(per_q);
   endproperty
   a_sync_gap: assert property (p_sync_gap)
      else $error("sync out spacing wrong");
   property p_auto_off; !sh_q[18] && !$past(sh_q[18]) |-> !auto_mode;
   endproperty
   a_auto_off: assert property (p_auto_off)
      else $error("auto mode while disabled");
endmodule : pcc_channel_ctrl_asserts
bind pcc_channel_ctrl pcc_channel_ctrl_asserts i_pcc_channel_ctrl_asserts (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .ext_sync(ext_sync),
   .limit_fault(limit_fault), .pin_a(pin_a), .sync_out(sync_out),
   .fine_phases(fine_phases), .rectifier_mode(rectifier_mode),
   .auto_mode(auto_mode));

// *** test_pwm_channel_control_one.sv ***
// Purpose: self-checking bench for the channel control block
// Assumes: apb slave answers after one wait state, 50 MHz pclk
// Notes: random ctrl1 words from a fixed seed beside corner cases
`timescale 1ns/10ps
`include "pcc_consts.svh"
module test_pwm_channel_control_one
   import pcc_pkg::*;
();
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, ext_sync = 1'b0, multi_mode = 1'b0;
   logic limit_fault = 1'b0, async_prot = 1'b0, frame_trigger = 1'b0;
   logic drv_a = 1'b0, drv_b = 1'b0, pready, pslverr, pin_a_i, pin_b_i;
   logic sync_out, sample_req, rectifier_mode, auto_mode;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [15:0] law_duty = 16'h0, balance_corr = 16'h0;
   logic [15:0] global_period = 16'h20;
   logic [4:0] fine_phases;
   pcc_pin_t pin_a, pin_b;
   int error_cnt = 0, compares = 0;
   always #10 pclk = ~pclk;
   pcc_channel_ctrl i_pcc_channel_ctrl (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .law_duty(law_duty), .balance_corr(balance_corr),
      .global_period(global_period), .ext_sync(ext_sync),
      .multi_mode(multi_mode), .limit_fault(limit_fault),
      .async_prot(async_prot), .frame_trigger(frame_trigger),
      .pin_a_i(pin_a_i), .pin_b_i(pin_b_i), .pin_a(pin_a), .pin_b(pin_b),
      .sync_out(sync_out), .sample_req(sample_req),
      .fine_phases(fine_phases), .rectifier_mode(rectifier_mode),
      .auto_mode(auto_mode));
   pcc_stage_model i_pcc_stage_model (.pin_a(pin_a), .pin_b(pin_b),
      .drv_a(drv_a), .drv_b(drv_b), .pin_a_i(pin_a_i), .pin_b_i(pin_b_i));
   // ==========================================
   // shared tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value at %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k >= 16)
         error_cnt++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask : rd
   // first two pulses after a change may carry a stale divider phase
   task automatic gap(output int g);
      repeat (3) begin
         g = 0;
         do begin
            @(posedge pclk);
            g++;
         end while (sync_out !== 1'b1 && g < 5000);
      end
   endtask : gap
   task automatic hi(input int n, input logic sel, output int c);
      c = 0;
      repeat (n) begin
         @(posedge pclk);
         c += sel ? sample_req : pin_a.o;
      end
   endtask : hi
   task automatic tally_and_finish;
      if (error_cnt == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (60000) @(posedge pclk);
      error_cnt++;
      tally_and_finish();
   end
   // ==========================================
   // scenarios
   initial begin
      logic [31:0] r, q, cb;
      logic e;
      int g, c;
      int ex[10] = '{16, 32, 8, 64, 4, 64, 2, 16, 16, 20};
      void'($urandom(21475));
      cb = `PCC_CTRL1_RST;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(`PCC_OFF_CTRL1, r);
      chk(r, cb);
      chk(fine_phases, 5'h10);
      apb(1'b1, 8'h08, 32'hffff_ffff, r, e);
      chk(e, 1'b1);
      apb(1'b0, 8'h08, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      for (int i = 0; i < 12; i++) begin
         r = $urandom;
         r[6] = 1'b0;
         r[3:2] = 2'(i);
         r[17:16] = 2'(i);
         wr(`PCC_OFF_CTRL1, r);
         rd(`PCC_OFF_CTRL1, q);
         chk(q, r);
         chk(rectifier_mode, r[30]);
         chk(fine_phases, 5'h10 >> r[3:2]);
      end
      for (int i = 0; i < 64; i++) begin
         drv_a <= 1'($urandom);
         drv_b <= 1'($urandom);
         wr(`PCC_OFF_CTRL1, cb | (32'(i) << 8));
         rd(`PCC_OFF_STATUS, r);
         if (i[0])
            chk(pin_a.o, i[1]);
         if (i[2])
            chk(pin_b.o, i[3]);
         chk({pin_a.oe, pin_b.oe}, {!i[4], !i[5]});
         chk(r[6:5], {i[5] ? drv_b : pin_b.o, i[4] ? drv_a : pin_a.o});
      end
      wr(`PCC_OFF_PERIOD, 32'h40);
      law_duty <= 16'h10;
      balance_corr <= 16'h4;
      for (int k = 0; k < 10; k++) begin
         wr(`PCC_OFF_CTRL1, cb | (k < 8 ? 32'(k) << 21 : 32'(k - 8) << 28));
         repeat (128) @(posedge pclk);
         hi(64, 1'b0, c);
         chk(c, ex[k]);
      end
      law_duty <= 16'hffff;
      async_prot <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         wr(`PCC_OFF_CTRL1, cb | (32'(k) << 4));
         repeat (4) @(posedge pclk);
         chk(pin_a.o, k[0]);
      end
      async_prot <= 1'b0;
      law_duty <= 16'h10;
      wr(`PCC_OFF_LEVELS, 32'hffff_ffff);
      for (int k = 1; k >= 0; k--) begin
         wr(`PCC_OFF_CTRL1, cb | (32'(k) << 29) | (32'(k) << 18));
         repeat (160) @(posedge pclk);
         rd(`PCC_OFF_STATUS, r);
         chk({r[2:1], auto_mode}, {3{k[0]}});
      end
      for (int k = 1; k >= 0; k--) begin
         wr(`PCC_OFF_CTRL1, (cb & ~32'h8000) | (32'(k) << 15));
         wr(`PCC_OFF_EVENTS, 32'h0010_0020);
         repeat (100) @(posedge pclk);
         rd(`PCC_OFF_STATUS, r);
         chk(r[0], !k[0]);
      end
      wr(`PCC_OFF_PRESET, 32'h20);
      for (int k = 0; k < 2; k++) begin
         wr(`PCC_OFF_CTRL1, cb | 32'h0010_0000 | (32'(k) << 31));
         ext_sync <= 1'b1;
         @(posedge pclk);
         ext_sync <= 1'b0;
         rd(`PCC_OFF_STATUS, r);
         chk(r[31:16] - (k ? 16'h20 : 16'h0) < 16'h8, 1'b1);
      end
      wr(`PCC_OFF_CTRL1, cb | 32'h4000);
      gap(g);
      chk(g, 32'h20);
      wr(`PCC_OFF_PERIOD, 32'h4);
      for (int k = 0; k < 4; k++) begin
         wr(`PCC_OFF_CTRL1, cb | (32'(k == 3 ? 15 : k) << 24));
         gap(g);
         chk(g, (k == 3 ? 16 : k + 1) * 4);
      end
      wr(`PCC_OFF_CTRL1, cb | 32'h40);
      for (int k = 0; k < 2; k++) begin
         if (k == 1)
            frame_trigger <= !frame_trigger;
         hi(40, 1'b1, c);
         chk(c, 1);
      end
      law_duty <= 16'hffff;
      multi_mode <= 1'b1;
      wr(`PCC_OFF_CTRL1, cb);
      limit_fault <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(pin_a.o, 1'b0);
      tally_and_finish();
   end
endmodule : test_pwm_channel_control_one
